// ---- core/ring_command_fetch_parser.sv ----
// Ring buffer command fetch DMA and packet parser.
`timescale 1ns/1ps
`default_nettype none
module ring_command_fetch_parser
    import ring_parser_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Window decode
    input wire logic [31:0] mmio_window_base_cfg,
    input wire logic [31:0] accessAddr,
    input wire logic ioCycle,
    output logic windowHit,
    // Ring programming strobes
    input wire logic startWrite,
    input wire logic [31:0] startValue,
    input wire logic [8:0] lengthPages,
    input wire logic tailWrite,
    input wire logic [20:0] tailValue,
    input wire logic headWrite,
    input wire logic [20:0] headValue,
    input wire logic ringEnable,
    input wire logic autoReportEnable,
    input wire logic [1:0] instruction_parser_mode_reg,
    // Ring status
    output logic [20:0] headOffset,
    output logic [10:0] wrapCount,
    output logic ringEmpty,
    output logic inBatch,
    output logic privViolation,
    // Fetch DMA read port
    output logic rdReq,
    output logic [31:0] rdAddr,
    input wire logic rdAck,
    input wire logic rdDataValid,
    input wire logic [31:0] rdData,
    // Head report write port
    output logic wrReq,
    output logic [31:0] wrData,
    input wire logic wrAck,
    // Engine ports
    output logic twoDValid,
    output logic renderValid,
    output logic [31:0] engineData,
    input wire logic twoDReady,
    input wire logic renderReady,
    input wire logic enginesIdle,
    // Memory interface command effects
    output logic flipPulse,
    output logic [31:0] miCommand
);
    typedef enum logic [3:0] {
        PS_IDLE = 4'b0001,
        PS_DISPATCH = 4'b0010,
        PS_BATCH_ADDR = 4'b0100,
        PS_FLUSH = 4'b1000
    } pstate_type;

    typedef struct packed {
        logic [31:0] startAddr;
        logic [20:0] head;
        logic [20:0] tail;
        logic [10:0] wraps;
        logic [20:0] fetchPtr;
        logic [31:0] batchPtr;
        logic batchArm;
        logic batchMode;
        logic [3:0] inFlight;
        logic [4:0] pendWords;
        logic [4:0] reportCnt;
        logic reportPend;
        logic violation;
        logic flip;
        logic [31:0] miCmd;
        logic [1:0] lastEngine;
        pstate_type ps;
    } state_type;

    state_type cur;
    state_type nxt;
    logic [20:0] ringDwords;
    logic [20:0] ringLast;
    logic headLast;
    logic fetchLast;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [31:0] fifoOutData;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic fifoFlush;
    logic [2:0] cmdType;
    logic [5:0] miOp;
    logic engineOk;
    logic consume;
    logic roomForRead;
    logic fetchPending;

    // The window size is fixed, so only the upper base bits take part in the match.
    assign windowHit = !ioCycle
        && ((accessAddr & MMIO_WINDOW_MASK) == (mmio_window_base_cfg & MMIO_WINDOW_MASK));

    assign ringDwords = 21'(lengthPages) * 21'(PAGE_DWORDS);
    assign ringLast = ringDwords - 21'h00_0001;
    assign headLast = (cur.head == ringLast);
    assign fetchLast = (cur.fetchPtr == ringLast);
    // Ring fetch stops at the tail, but batch fetch does not; in-flight reads are counted so the FIFO never overflows.
    assign fetchPending = cur.batchMode ? 1'b1 : (cur.fetchPtr != cur.tail);
    assign roomForRead = (32'(fifoLevel) + 32'(cur.inFlight)) < FIFO_DEPTH;
    assign rdReq = ringEnable && fetchPending && roomForRead && !cur.batchArm;
    assign rdAddr = cur.batchMode ? cur.batchPtr
        : cur.startAddr + {9'h000, cur.fetchPtr, 2'b00};
    assign fifoFlush = startWrite || headWrite;

    assign cmdType = fifoOutData[31:29];
    assign miOp = fifoOutData[28:23];
    assign engineOk = (cmdType == CT_TWO_D) ? twoDReady : renderReady;

    always_comb begin
        twoDValid = 1'b0;
        renderValid = 1'b0;
        fifoOutReady = 1'b0;
        if (cur.ps == PS_DISPATCH && fifoOutValid) begin
            if (cmdType == CT_MEM_IF) begin
                fifoOutReady = 1'b1;
            end else if (cmdType == CT_TWO_D && instruction_parser_mode_reg[0] == 1'b0) begin
                twoDValid = 1'b1;
                fifoOutReady = twoDReady;
            end else if (cmdType != CT_TWO_D && instruction_parser_mode_reg[1] == 1'b0) begin
                renderValid = 1'b1;
                fifoOutReady = renderReady;
            end else begin
                fifoOutReady = 1'b1;
            end
        end else if (cur.ps == PS_BATCH_ADDR && fifoOutValid) begin
            fifoOutReady = 1'b1;
        end
    end
    assign consume = fifoOutValid && fifoOutReady;
    assign engineData = fifoOutData;

    always_comb begin
        nxt = cur;
        nxt.flip = 1'b0;
        if (rdReq && rdAck) begin
            nxt.inFlight = cur.inFlight + 4'h1;
            if (cur.batchMode) begin
                nxt.batchPtr = cur.batchPtr + 32'(DWORD_BYTES);
            end else begin
                nxt.fetchPtr = fetchLast ? 21'h00_0000 : cur.fetchPtr + 21'h00_0001;
            end
        end
        if (rdDataValid) begin
            nxt.inFlight = nxt.inFlight - 4'h1;
        end
        // The acknowledge clears first so that a new report in the same cycle is not lost.
        if (wrReq && wrAck) begin
            nxt.reportPend = 1'b0;
        end
        if (consume && !cur.batchMode) begin
            nxt.head = headLast ? 21'h00_0000 : cur.head + 21'h00_0001;
            if (headLast) begin
                nxt.wraps = cur.wraps + 11'h001;
            end
            if (autoReportEnable && (cur.head[13:0] == 14'(REPORT_STRIDE_64K_DW - 1))) begin
                nxt.reportPend = 1'b1;
            end
        end
        case (cur.ps)
            PS_IDLE: begin
                if (fifoOutValid) begin
                    nxt.ps = PS_DISPATCH;
                end
            end
            PS_DISPATCH: begin
                if (consume) begin
                    nxt.lastEngine = cmdType[1:0];
                    if (cmdType == CT_MEM_IF) begin
                        nxt.miCmd = fifoOutData;
                        if (cur.batchMode && miOp == MI_OP_PRIV_STORE) begin
                            nxt.violation = 1'b1;
                        end else if (miOp == MI_OP_BATCH_START && !cur.batchMode) begin
                            nxt.ps = PS_BATCH_ADDR;
                        end else if (miOp == MI_OP_BATCH_END && cur.batchMode) begin
                            nxt.batchMode = 1'b0;
                        end else if (miOp == MI_OP_FLUSH) begin
                            nxt.ps = PS_FLUSH;
                        end else if (miOp == MI_OP_FLIP) begin
                            nxt.flip = 1'b1;
                        end else if (miOp == MI_OP_REPORT_HEAD) begin
                            nxt.reportPend = 1'b1;
                        end
                    end
                end else if (!fifoOutValid) begin
                    nxt.ps = PS_IDLE;
                end
            end
            PS_BATCH_ADDR: begin
                // Ring prefetch beyond the batch start word is still dispatched, and the batch only starts once the FIFO has drained.
                if (consume) begin
                    nxt.batchPtr = {fifoOutData[31:2], 2'b00};
                    nxt.batchArm = 1'b1;
                    nxt.ps = PS_IDLE;
                end
            end
            PS_FLUSH: begin
                if (enginesIdle) begin
                    nxt.ps = PS_IDLE;
                end
            end
            default: begin
                nxt.ps = PS_IDLE;
            end
        endcase
        if (cur.batchArm && cur.inFlight == 4'h0 && fifoLevel == '0) begin
            nxt.batchArm = 1'b0;
            nxt.batchMode = 1'b1;
            nxt.fetchPtr = cur.head;
        end
        if (!cur.batchMode && nxt.batchMode == 1'b0 && cur.batchArm == 1'b0 && consume
                && cur.ps == PS_DISPATCH && miOp == MI_OP_BATCH_END && cmdType == CT_MEM_IF) begin
            nxt.fetchPtr = nxt.head;
        end
        if (tailWrite) begin
            nxt.tail = tailValue;
        end
        if (headWrite) begin
            nxt.head = headValue;
            nxt.fetchPtr = headValue;
        end
        if (startWrite) begin
            nxt.startAddr = {startValue[31:12], 12'h000};
            nxt.head = HEAD_RESET;
            nxt.wraps = WRAP_RESET;
            nxt.fetchPtr = HEAD_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur <= '{startAddr: 32'h0000_0000, head: HEAD_RESET, tail: HEAD_RESET, wraps: WRAP_RESET,
                fetchPtr: HEAD_RESET, batchPtr: 32'h0000_0000, batchArm: 1'b0, batchMode: 1'b0,
                inFlight: 4'h0, pendWords: 5'h00, reportCnt: 5'h00, reportPend: 1'b0,
                violation: 1'b0, flip: 1'b0, miCmd: 32'h0000_0000, lastEngine: 2'h0, ps: PS_IDLE};
        end else begin
            cur <= nxt;
        end
    end

    ring_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .inValid(rdDataValid),
        .inReady(fifoInReady),
        .inData(rdData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData),
        .level(fifoLevel),
        .flush(fifoFlush)
    );

    assign headOffset = cur.head;
    assign wrapCount = cur.wraps;
    assign ringEmpty = (cur.head == cur.tail);
    assign inBatch = cur.batchMode;
    assign privViolation = cur.violation;
    assign wrReq = cur.reportPend;
    assign wrData = {cur.wraps, cur.head};
    assign flipPulse = cur.flip;
    assign miCommand = cur.miCmd;
endmodule
`default_nettype wire

// ---- core/ring_fifo.sv ----
// Word FIFO between the fetch DMA and the packet parser.
`timescale 1ns/1ps
`default_nettype none
module ring_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // Occupancy
    output logic [$clog2(DEPTH):0] level,
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWrite;
    logic doRead;

    assign inReady = (count != (AW+1)'(DEPTH)) && !flush;
    assign outValid = (count != '0) && !flush;
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr];
    assign level = count;

    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            end
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// ---- pkg/ring_parser_pkg.sv ----
// Shared constants and types for the ring command fetch parser.
package ring_parser_pkg;
    localparam int MMIO_WINDOW_BYTES = 512 * 1024;
    localparam logic [31:0] MMIO_WINDOW_MASK = 32'hFFF8_0000;
    localparam int DWORD_BYTES = 4;
    localparam int PAGE_DWORDS = 1024;
    localparam int REPORT_STRIDE_64K_DW = 16384;
    localparam logic [2:0] CT_MEM_IF = 3'h0;
    localparam logic [2:0] CT_TWO_D = 3'h2;
    localparam logic [2:0] CT_RENDER = 3'h3;
    localparam logic [1:0] PMODE_RESET = 2'h0;
    localparam logic [5:0] MI_OP_BATCH_START = 6'h31;
    localparam logic [5:0] MI_OP_BATCH_END = 6'h0A;
    localparam logic [5:0] MI_OP_FLUSH = 6'h04;
    localparam logic [5:0] MI_OP_FLIP = 6'h14;
    localparam logic [5:0] MI_OP_REPORT_HEAD = 6'h07;
    localparam logic [5:0] MI_OP_PRIV_STORE = 6'h20;
    localparam logic [20:0] HEAD_RESET = 21'h00_0000;
    localparam logic [10:0] WRAP_RESET = 11'h000;
endpackage

// ---- tb/ring_command_fetch_parser_checker.sv ----
// Concurrent checks on the ports of the ring command fetch parser.
`timescale 1ns/1ps
`default_nettype none
module ring_command_fetch_parser_checker
    import ring_parser_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Window decode
    input wire logic [31:0] mmio_window_base_cfg,
    input wire logic [31:0] accessAddr,
    input wire logic ioCycle,
    input wire logic windowHit,
    // Ring control
    input wire logic startWrite,
    input wire logic headWrite,
    input wire logic tailWrite,
    input wire logic [20:0] tailValue,
    input wire logic ringEnable,
    input wire logic [1:0] instruction_parser_mode_reg,
    // Status and traffic
    input wire logic [20:0] headOffset,
    input wire logic [10:0] wrapCount,
    input wire logic ringEmpty,
    input wire logic inBatch,
    input wire logic rdReq,
    input wire logic wrReq,
    input wire logic wrAck,
    input wire logic renderValid,
    input wire logic renderReady,
    input wire logic [31:0] engineData
);
    // The tail only shows up as a strobe, so a copy is kept here to judge emptiness.
    logic [20:0] tailSeen;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tailSeen <= 21'h00_0000;
        end else if (tailWrite) begin
            tailSeen <= tailValue;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_render_stall;
        renderValid && !renderReady;
    endsequence
    sequence s_render_kept;
        renderValid && $stable(engineData);
    endsequence
    a_window_io: assert property (ioCycle |-> !windowHit) else $error("window hit on io cycle");
    a_window_match: assert property (
        !ioCycle |-> windowHit == ((accessAddr & MMIO_WINDOW_MASK) == (mmio_window_base_cfg & MMIO_WINDOW_MASK))
    ) else $error("window decode wrong");
    a_empty_flag: assert property (ringEmpty == (headOffset == tailSeen)) else $error("empty flag wrong");
    a_no_fetch_off: assert property (
        !ringEnable && !inBatch && !rdReq |=> !rdReq || ringEnable
    ) else $error("fetch while ring off");
    a_head_step: assert property (
        $changed(headOffset) && !$past(headWrite) && !$past(startWrite)
            |-> headOffset == $past(headOffset) + 21'd1 || headOffset == HEAD_RESET
    ) else $error("head moved by other than one");
    a_wrap_count: assert property (
        $changed(wrapCount) |-> headOffset == HEAD_RESET
            && (wrapCount == $past(wrapCount) + 11'd1 || wrapCount == WRAP_RESET)
    ) else $error("wrap count moved without wrap");
    a_start_clear: assert property (
        startWrite |=> headOffset == HEAD_RESET && wrapCount == WRAP_RESET
    ) else $error("start write kept head");
    a_render_hold: assert property (s_render_stall |=> s_render_kept) else $error("render word not held");
    a_mode_drop: assert property (
        instruction_parser_mode_reg[1] && !renderValid |=> !renderValid || !instruction_parser_mode_reg[1]
    ) else $error("render word passed while dropped");
    a_report_hold: assert property (wrReq && !wrAck |=> wrReq) else $error("head report dropped");
endmodule
bind ring_command_fetch_parser ring_command_fetch_parser_checker chk (.*);
`default_nettype wire

// ---- tb/ring_command_fetch_parser_test.sv ----
// Self-checking testbench for the ring command fetch parser.
`timescale 1ns/1ps
`default_nettype none
module ring_command_fetch_parser_test;
    import ring_parser_pkg::*;
    localparam logic [31:0] RING_BASE = 32'h0001_0000;
    logic clk_sys, rstn, ioCycle, startWrite, tailWrite, headWrite, ringEnable, windowHit, ringEmpty, inBatch;
    logic privViolation, rdReq, rdAck, rdDataValid, wrReq, wrAck, twoDValid, renderValid, renderReady, flipPulse;
    logic [31:0] mmio_window_base_cfg, accessAddr, startValue, rdAddr, rdData, wrData, engineData, miCommand;
    logic [20:0] tailValue, headValue, headOffset;
    logic [10:0] wrapCount;
    logic [1:0] instruction_parser_mode_reg;
    int n_mismatch, n_checks, cycles;
    int flips, reports;
    // One page of ring keeps the wrap reachable in a short run.
    ring_command_fetch_parser dut (.lengthPages(9'h001), .autoReportEnable(1'b0), .enginesIdle(1'b1),
        .twoDReady(1'b1), .*);
    ring_memory_model mem (.*);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Pulses are counted at the edge, where the registered outputs are settled.
    always @(posedge clk_sys) begin
        flips += flipPulse;
        reports += (wrReq && wrAck);
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic put_tail(input logic [20:0] t);
        tailValue = t;
        tailWrite = 1'b1;
        step(1);
        tailWrite = 1'b0;
    endtask
    task automatic wait_head(input logic [20:0] h);
        for (int i = 0; i < 300 && headOffset !== h; i++) step(1);
    endtask
    task automatic t_window();
        mmio_window_base_cfg = 32'hC008_0000;
        accessAddr = 32'hC00F_FFFC;
        step(1);
        chk("window inside", 32'h0000_0001, {31'h0, windowHit});
        accessAddr = 32'hC010_0000;
        step(1);
        chk("window above", 32'h0000_0000, {31'h0, windowHit});
        accessAddr = 32'hC008_0000;
        ioCycle = 1'b1;
        step(1);
        chk("window io", 32'h0000_0000, {31'h0, windowHit});
        ioCycle = 1'b0;
        $display("t_window done");
    endtask
    task automatic t_fetch();
        startValue = RING_BASE;
        startWrite = 1'b1;
        step(1);
        startWrite = 1'b0;
        ringEnable = 1'b1;
        renderReady = 1'b0;
        step(5);
        chk("read before tail", 32'h0000_0000, {31'h0, rdReq});
        put_tail(21'h00_0002);
        for (int i = 0; i < 100 && renderValid !== 1'b1; i++) step(1);
        chk("first word", {3'b011, RING_BASE[30:2]}, engineData);
        step(3);
        chk("stalled head", 32'h0000_0000, {11'h0, headOffset});
        chk("stalled valid", 32'h0000_0001, {31'h0, renderValid});
        renderReady = 1'b1;
        wait_head(21'h00_0002);
        chk("head at tail", 32'h0000_0002, {11'h0, headOffset});
        step(10);
        chk("head stays", 32'h0000_0002, {11'h0, headOffset});
        chk("empty", 32'h0000_0001, {31'h0, ringEmpty});
        $display("t_fetch done");
    endtask
    task automatic t_drop();
        int seen;
        seen = 0;
        instruction_parser_mode_reg = 2'b10;
        put_tail(21'h00_0004);
        for (int i = 0; i < 40; i++) begin
            step(1);
            seen += renderValid;
        end
        chk("dropped render", 32'h0000_0000, seen);
        instruction_parser_mode_reg = 2'b00;
        $display("t_drop done");
    endtask
    task automatic t_wrap();
        headValue = 21'h00_03FE;
        headWrite = 1'b1;
        step(1);
        headWrite = 1'b0;
        put_tail(21'h00_0002);
        wait_head(21'h00_0002);
        chk("wrapped head", 32'h0000_0002, {11'h0, headOffset});
        chk("wrap count", 32'h0000_0001, {21'h0, wrapCount});
        startWrite = 1'b1;
        step(1);
        startWrite = 1'b0;
        chk("start clears head", 32'h0000_0000, {11'h0, headOffset});
        chk("start clears wraps", 32'h0000_0000, {21'h0, wrapCount});
        $display("t_wrap done");
    endtask
    task automatic t_mi();
        flips = 0;
        reports = 0;
        put_tail(21'h00_0012);
        wait_head(21'h00_0012);
        step(20);
        chk("head after mi", 32'h0000_0012, {11'h0, headOffset});
        chk("flip pulses", 32'h0000_0001, flips);
        chk("head reports", 32'h0000_0001, reports);
        chk("last mi word", {CT_MEM_IF, MI_OP_REPORT_HEAD, 23'h00_0000}, miCommand);
        chk("report cleared", 32'h0000_0000, {31'h0, wrReq});
        $display("t_mi done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        {rstn, ioCycle, startWrite, tailWrite, headWrite, ringEnable, renderReady} = 7'h00;
        {mmio_window_base_cfg, accessAddr, startValue} = 96'h0;
        {tailValue, headValue} = 42'h0;
        instruction_parser_mode_reg = 2'b00;
        step(16);
        rstn = 1'b1;
        t_window();
        t_fetch();
        t_drop();
        t_wrap();
        t_mi();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- tb/ring_memory_model.sv ----
// Behavioural system memory answering the parser's fetch reads and head report writes.
`timescale 1ns/1ps
`default_nettype none
module ring_memory_model (
    // Clock
    input wire logic clk_sys,
    // Read port
    input wire logic rdReq,
    input wire logic [31:0] rdAddr,
    output logic rdAck,
    output logic rdDataValid,
    output logic [31:0] rdData,
    // Write port
    input wire logic wrReq,
    output logic wrAck
);
    logic [31:0] pending;
    logic [1:0] pause;
    logic [1:0] wait_left;
    initial begin
        rdAck = 1'b0;
        rdDataValid = 1'b0;
        rdData = 32'h0000_0000;
        wrAck = 1'b0;
        pause = 2'h0;
        wait_left = 2'h0;
    end
    // Every dword outside the two fixed slots is a render word carrying its own dword address, so order slips show up.
    always @(posedge clk_sys) begin
        #1;
        wrAck = wrReq && !wrAck;
        rdDataValid = 1'b0;
        rdData = ~rdData;
        if (rdAck) begin
            rdAck = 1'b0;
            rdDataValid = 1'b1;
            rdData = pending;
        end else if (rdReq && wait_left != 2'h0) begin
            wait_left = wait_left - 2'h1;
        end else if (rdReq) begin
            rdAck = 1'b1;
            // Two fixed ring slots hold memory interface words: a flip, then a head report.
            if (rdAddr[11:2] == 10'h010) begin
                pending = {ring_parser_pkg::CT_MEM_IF, ring_parser_pkg::MI_OP_FLIP, 23'h00_0000};
            end else if (rdAddr[11:2] == 10'h011) begin
                pending = {ring_parser_pkg::CT_MEM_IF, ring_parser_pkg::MI_OP_REPORT_HEAD, 23'h00_0000};
            end else begin
                pending = {3'b011, rdAddr[30:2]};
            end
            pause = pause + 2'h1;
            wait_left = pause;
        end
    end
endmodule
`default_nettype wire
